// >>> hdl/cssr_map.vh
// cssr_map.vh: offsets, bit positions and reset values of the status flag block
// assumes inclusion by bare name from the block's design files
`ifndef CSSR_MAP_VH
`define CSSR_MAP_VH

// register offsets on the apb bus
`define CSSR_ADDR_W 12
`define CSSR_OFF_FLAGS 12'h000
`define CSSR_OFF_CTRL 12'h004

// cpu_status_flags bit positions
`define CSSR_B_OA 15
`define CSSR_B_OB 14
`define CSSR_B_SA 13
`define CSSR_B_SB 12
`define CSSR_B_OAB 11
`define CSSR_B_SAB 10
`define CSSR_B_DA 9
`define CSSR_B_DC 8
`define CSSR_B_IPL_HI 7
`define CSSR_B_IPL_LO 5
`define CSSR_B_RA 4
`define CSSR_B_N 3
`define CSSR_B_OV 2
`define CSSR_B_Z 1
`define CSSR_B_C 0

// control register bit positions
`define CSSR_B_NEST_DIS 0

// one-hot select positions of the address decode
`define CSSR_SEL_FLAGS 0
`define CSSR_SEL_CTRL 1
`define CSSR_SEL_NONE 2'h0

// reset values
`define CSSR_FLAG_RST 1'b0
`define CSSR_IPL_RST 3'h0
`define CSSR_COND_RST 4'h0
`define CSSR_CTRL_RST 1'b0
`define CSSR_RDATA_RST 32'h0000_0000

`endif

// >>> hdl/cssr_sticky.v
// cssr_sticky.v: one sticky flag, set by hardware, cleared by software
// assumes set and clear come from logic on ref_clk
`default_nettype none

module cssr_sticky (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// control
	input wire set_in,
	input wire clr_in,
	// state
	output wire nxt_q,
	output reg q_ff
);

`include "cssr_map.vh"

// set wins over a clear in the same cycle
assign nxt_q = set_in | (q_ff & ~clr_in);

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		q_ff <= `CSSR_FLAG_RST;
	end else begin
		q_ff <= nxt_q;
	end
end

endmodule // cssr_sticky

`default_nettype wire

// >>> hdl/cssr_top.v
// cssr_top.v: cpu status flag register with apb slave access
// assumes datapath, loop sequencer and priority inputs are on ref_clk
//
// What this block does
// - overflow flags for accumulator one (bit 15) and two (bit 14), read-only
// - sticky clip flags at bits 13 and 12 stay set until cleared
// - bit 11 reads the or of both overflow flags, read-only
// - bit 10 is set when either accumulator clips now or clipped before
// - clearing bit 10 also clears both per-accumulator sticky clip flags
// - sticky flags are readable and clearable, a written one never sets them
// - bit 9 is read-only and shows a running do loop
// - half carry at bit 8 from bit 3 carry (byte) or bit 7 carry (word)
// - priority level in bits 7 to 5, resets to zero, software writable
// - priority field ignores software writes while nesting disable is set
// - bit 4 read-only status, bits 3 to 0 condition flags read/write, reset zero
// - upper byte access types as listed, all resetting to zero
//
// The placing of the registers and the APB slave port are this design's own decisions.
`default_nettype none

module cssr_top (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// accumulator status from datapath
	input wire acc_a_ovf,
	input wire acc_b_ovf,
	input wire acc_a_sat,
	input wire acc_b_sat,
	// loop sequencer status
	input wire do_loop_act,
	input wire rep_act,
	// arithmetic result flags
	input wire alu_upd,
	input wire alu_byte_op,
	input wire alu_carry_nib,
	input wire alu_carry_byte,
	input wire cond_upd,
	input wire [3:0] cond_in,
	// priority load from interrupt logic
	input wire ipl_load,
	input wire [2:0] ipl_in,
	// register view for the core
	output wire [15:0] cpu_status_flags,
	output wire nesting_disable
);

`include "cssr_map.vh"

// one-hot decode: bit 0 flags word, bit 1 control word
function [1:0] cssr_dec;
	input [11:0] addr;
	begin
		cssr_dec = `CSSR_SEL_NONE;
		if (addr == `CSSR_OFF_FLAGS) begin
			cssr_dec[`CSSR_SEL_FLAGS] = 1'b1;
		end
		if (addr == `CSSR_OFF_CTRL) begin
			cssr_dec[`CSSR_SEL_CTRL] = 1'b1;
		end
	end
endfunction

// write strobe for one decoded register in the completing cycle
function cssr_wr_hit;
	input acc;
	input wr;
	input hit;
	begin
		cssr_wr_hit = acc & wr & hit;
	end
endfunction

// a written zero on the own bit or on the combined bit clears a sticky
function cssr_clr;
	input wr_en;
	input own_bit;
	input sum_bit;
	begin
		cssr_clr = wr_en & (~own_bit | ~sum_bit);
	end
endfunction

// combined summary of the two accumulator flags
function cssr_any2;
	input a_flag;
	input b_flag;
	begin
		cssr_any2 = a_flag | b_flag;
	end
endfunction

// read word for a decoded select, zero outside the mapped bits
function [31:0] cssr_rd_word;
	input [1:0] sel;
	input [15:0] flags;
	input nest;
	begin
		cssr_rd_word = `CSSR_RDATA_RST;
		if (sel[`CSSR_SEL_FLAGS]) begin
			cssr_rd_word[`CSSR_B_OA:`CSSR_B_C] = flags;
		end
		if (sel[`CSSR_SEL_CTRL]) begin
			cssr_rd_word[`CSSR_B_NEST_DIS] = nest;
		end
	end
endfunction

// register state
reg first_acc_overflow_ff;
reg second_acc_overflow_ff;
reg either_acc_overflow_ff;
reg either_acc_clip_sticky_ff;
reg do_loop_running_ff;
reg half_carry_flag_ff;
reg [2:0] cpu_priority_level_ff;
reg rep_active_ff;
reg [3:0] cond_flags_ff;
reg nesting_disable_ff;
reg [31:0] prdata_ff;

// next values
reg nxt_half_carry_flag;
reg [2:0] nxt_cpu_priority_level;
reg [3:0] nxt_cond_flags;
reg nxt_nesting_disable;
reg [31:0] nxt_prdata;

// bus decode
wire [1:0] sel_hit;
wire hit_any;
wire setup_ph;
wire access_ph;
wire wr_flags;
wire wr_ctrl;
wire wr_ipl;

// sticky clip controls and state
wire clr_first_clip;
wire clr_second_clip;
wire nxt_first_clip;
wire nxt_second_clip;
wire first_acc_clip_sticky_ff;
wire second_acc_clip_sticky_ff;
wire half_carry_src;
wire [15:0] flags_view;

assign sel_hit = cssr_dec(paddr);
assign hit_any = |sel_hit;
assign setup_ph = psel & ~penable;
assign access_ph = psel & penable;

// zero wait state slave, error on an unmapped address
assign pready = access_ph;
assign pslverr = access_ph & ~hit_any;
assign prdata = prdata_ff;

// writes take effect at the completing edge only
assign wr_flags = cssr_wr_hit(access_ph, pwrite, sel_hit[`CSSR_SEL_FLAGS]);
assign wr_ctrl = cssr_wr_hit(access_ph, pwrite, sel_hit[`CSSR_SEL_CTRL]);
assign wr_ipl = wr_flags & ~nesting_disable_ff;

// sticky clip flags: a written zero clears, a written one is ignored
assign clr_first_clip = cssr_clr(wr_flags, pwdata[`CSSR_B_SA],
	pwdata[`CSSR_B_SAB]);
assign clr_second_clip = cssr_clr(wr_flags, pwdata[`CSSR_B_SB],
	pwdata[`CSSR_B_SAB]);

cssr_sticky u_first_clip (
	.ref_clk(ref_clk),
	.rst(rst),
	.set_in(acc_a_sat),
	.clr_in(clr_first_clip),
	.nxt_q(nxt_first_clip),
	.q_ff(first_acc_clip_sticky_ff)
);

cssr_sticky u_second_clip (
	.ref_clk(ref_clk),
	.rst(rst),
	.set_in(acc_b_sat),
	.clr_in(clr_second_clip),
	.nxt_q(nxt_second_clip),
	.q_ff(second_acc_clip_sticky_ff)
);

// overflow flags follow the datapath, software cannot write them
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		first_acc_overflow_ff <= `CSSR_FLAG_RST;
		second_acc_overflow_ff <= `CSSR_FLAG_RST;
	end else begin
		first_acc_overflow_ff <= acc_a_ovf;
		second_acc_overflow_ff <= acc_b_ovf;
	end
end

// combined overflow, read-only
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		either_acc_overflow_ff <= `CSSR_FLAG_RST;
	end else begin
		either_acc_overflow_ff <= cssr_any2(acc_a_ovf, acc_b_ovf);
	end
end

// loop and repeat status, read-only
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		do_loop_running_ff <= `CSSR_FLAG_RST;
		rep_active_ff <= `CSSR_FLAG_RST;
	end else begin
		do_loop_running_ff <= do_loop_act;
		rep_active_ff <= rep_act;
	end
end

// combined sticky follows the or of both sticky next values
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		either_acc_clip_sticky_ff <= `CSSR_FLAG_RST;
	end else begin
		either_acc_clip_sticky_ff <= cssr_any2(nxt_first_clip, nxt_second_clip);
	end
end

// half carry source picks the carry out of bit 3 or bit 7
assign half_carry_src = alu_byte_op ? alu_carry_nib : alu_carry_byte;

// half carry: datapath update beats a software write in the same cycle
always @* begin
	nxt_half_carry_flag = half_carry_flag_ff;
	if (alu_upd) begin
		nxt_half_carry_flag = half_carry_src;
	end else if (wr_flags) begin
		nxt_half_carry_flag = pwdata[`CSSR_B_DC];
	end
end

// priority level: interrupt load first, then software unless locked
always @* begin
	nxt_cpu_priority_level = cpu_priority_level_ff;
	if (ipl_load) begin
		nxt_cpu_priority_level = ipl_in;
	end else if (wr_ipl) begin
		nxt_cpu_priority_level = pwdata[`CSSR_B_IPL_HI:`CSSR_B_IPL_LO];
	end
end

// condition flags: datapath update beats a software write
always @* begin
	nxt_cond_flags = cond_flags_ff;
	if (cond_upd) begin
		nxt_cond_flags = cond_in;
	end else if (wr_flags) begin
		nxt_cond_flags = pwdata[`CSSR_B_N:`CSSR_B_C];
	end
end

// control register
always @* begin
	nxt_nesting_disable = nesting_disable_ff;
	if (wr_ctrl) begin
		nxt_nesting_disable = pwdata[`CSSR_B_NEST_DIS];
	end
end

// half carry flop
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		half_carry_flag_ff <= `CSSR_FLAG_RST;
	end else begin
		half_carry_flag_ff <= nxt_half_carry_flag;
	end
end

// priority level flop
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		cpu_priority_level_ff <= `CSSR_IPL_RST;
	end else begin
		cpu_priority_level_ff <= nxt_cpu_priority_level;
	end
end

// condition flag flops
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		cond_flags_ff <= `CSSR_COND_RST;
	end else begin
		cond_flags_ff <= nxt_cond_flags;
	end
end

// control register flop
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		nesting_disable_ff <= `CSSR_CTRL_RST;
	end else begin
		nesting_disable_ff <= nxt_nesting_disable;
	end
end

// assembled view; read-only bits never take bus data
assign flags_view[`CSSR_B_OA] = first_acc_overflow_ff;
assign flags_view[`CSSR_B_OB] = second_acc_overflow_ff;
assign flags_view[`CSSR_B_SA] = first_acc_clip_sticky_ff;
assign flags_view[`CSSR_B_SB] = second_acc_clip_sticky_ff;
assign flags_view[`CSSR_B_OAB] = either_acc_overflow_ff;
assign flags_view[`CSSR_B_SAB] = either_acc_clip_sticky_ff;
assign flags_view[`CSSR_B_DA] = do_loop_running_ff;
assign flags_view[`CSSR_B_DC] = half_carry_flag_ff;
assign flags_view[`CSSR_B_IPL_HI:`CSSR_B_IPL_LO] = cpu_priority_level_ff;
assign flags_view[`CSSR_B_RA] = rep_active_ff;
assign flags_view[`CSSR_B_N:`CSSR_B_C] = cond_flags_ff;

assign cpu_status_flags = flags_view;
assign nesting_disable = nesting_disable_ff;

// read data captured in the setup cycle, zero for unmapped
always @* begin
	nxt_prdata = prdata_ff;
	if (setup_ph) begin
		nxt_prdata = cssr_rd_word(sel_hit, flags_view, nesting_disable_ff);
	end
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		prdata_ff <= `CSSR_RDATA_RST;
	end else begin
		prdata_ff <= nxt_prdata;
	end
end

endmodule // cssr_top

`default_nettype wire

// >>> dv/cssr_top_asserts.sv
// cssr_top_asserts.sv: port timing checks for the status flag block
// assumes bind to cssr_top, inputs change after ref_clk rising edges
`default_nettype none
module cssr_top_asserts (
	// clock, reset, apb
	input wire logic ref_clk, rst, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// datapath side
	input wire logic acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat, do_loop_act,
	input wire logic alu_upd, alu_byte_op, alu_carry_nib, alu_carry_byte, ipl_load,
	// register view
	input wire logic [15:0] cpu_status_flags,
	input wire logic nesting_disable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic [15:0] s = cpu_status_flags;
	wire logic wr = psel && penable && pwrite && paddr == 12'h000;
	wire logic hc = alu_byte_op ? alu_carry_nib : alu_carry_byte;
	AST_OVF: assert property (acc_a_ovf |=> s[15] && s[11])
		else $error("overflow flag not set");
	AST_STKY: assert property (acc_b_sat |=> s[12] && s[10])
		else $error("sticky flag not set");
	AST_SAB: assert property (s[10] == (s[13] | s[12]))
		else $error("combined sticky wrong");
	AST_CLR: assert property (wr && !pwdata[10] && !acc_a_sat && !acc_b_sat |=> !s[13] && !s[12])
		else $error("stickies not cleared");
	AST_NOSET: assert property (wr && !s[13] && !acc_a_sat |=> !s[13])
		else $error("sticky set by write");
	AST_LOOP: assert property (s[9] == $past(do_loop_act))
		else $error("loop flag wrong");
	AST_HC: assert property (alu_upd |=> s[8] == $past(hc))
		else $error("half carry wrong");
	AST_LOCK: assert property (nesting_disable && !ipl_load |=> $stable(s[7:5]))
		else $error("priority changed while locked");
	cover property (wr && nesting_disable);
	cover property (wr && acc_a_sat);
	cover property (alu_upd && alu_byte_op);
endmodule // cssr_top_asserts
`default_nettype wire

// >>> dv/cssr_dp_model.sv
// cssr_dp_model.sv: random datapath, loop and priority source
// assumes ref_clk and rst shared with the block
`default_nettype none
module cssr_dp_model (
	// clock, reset, enable
	input wire logic ref_clk, rst, en,
	// packed datapath outputs and random word
	output logic [18:0] dp,
	output logic [31:0] rnd
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rnd <= 32'h0000_0046;
			dp <= 19'h0_0000;
		end else begin
			rnd <= lfsr(rnd);
			dp <= en ? rnd[18:0] : 19'h0_0000;
		end
	end
endmodule // cssr_dp_model
`default_nettype wire

// >>> dv/cpu_status_flag_register_test.sv
// cpu_status_flag_register_test.sv: self-checking bench for the flag block
// assumes cssr_top, checker and datapath model compiled first
`default_nettype none
module cpu_status_flag_register_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, nesting_disable, en, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd, rd;
	logic [18:0] dp;
	logic [15:0] cpu_status_flags, ref_v, mdl;
	logic mlk, wr_f, wr_c;
	int error_cnt, comparisons;
	cssr_dp_model dpm (.ref_clk(ref_clk), .rst(rst), .en(en), .dp(dp), .rnd(rnd));
	cssr_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_a_ovf(dp[0]), .acc_b_ovf(dp[1]), .acc_a_sat(dp[2]),
		.acc_b_sat(dp[3]), .do_loop_act(dp[4]), .rep_act(dp[5]), .alu_upd(dp[6]),
		.alu_byte_op(dp[7]), .alu_carry_nib(dp[8]), .alu_carry_byte(dp[9]),
		.cond_upd(dp[10]), .cond_in(dp[14:11]), .ipl_load(dp[15]), .ipl_in(dp[18:16]),
		.cpu_status_flags(cpu_status_flags), .nesting_disable(nesting_disable));
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	function automatic logic [15:0] exp_w(input logic [15:0] old, w, input logic lk);
		exp_w = (w & 16'h010F) | ((lk ? old : w) & 16'h00E0);
	endfunction
	function automatic logic [15:0] nxt_flags(input logic [15:0] f, w,
		input logic [18:0] d, input logic wr, lk);
		logic sa, sb;
		sa = d[2] | (f[13] & ~(wr & ~(w[13] & w[10])));
		sb = d[3] | (f[12] & ~(wr & ~(w[12] & w[10])));
		nxt_flags = {d[0], d[1], sa, sb, d[0] | d[1], sa | sb, d[4],
			d[6] ? (d[7] ? d[8] : d[9]) : (wr ? w[8] : f[8]),
			d[15] ? d[18:16] : (wr && !lk ? w[7:5] : f[7:5]), d[5],
			d[10] ? d[14:11] : (wr ? w[3:0] : f[3:0])};
	endfunction
	assign wr_f = psel && penable && pwrite && paddr == 12'h000;
	assign wr_c = psel && penable && pwrite && paddr == 12'h004;
	always @(posedge ref_clk) begin
		if (rst) begin
			mdl <= 0;
			mlk <= 0;
		end else begin
			check(cpu_status_flags, mdl);
			check(nesting_disable, mlk);
			mdl <= nxt_flags(mdl, pwdata[15:0], dp, wr_f, mlk);
			if (wr_c)
				mlk <= pwdata[0];
		end
	end
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		logic [15:0] w;
		rst = 1;
		{psel, penable, pwrite, paddr, pwdata, en, ref_v} = 0;
		repeat (10) @(posedge ref_clk);
		rst <= 0;
		apb(0, 12'h000, 0);
		check(rd, 0);
		check(err, 0);
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			if (i == 8)
				apb(1, 12'h004, 1);
			w = rnd[15:0];
			ref_v = exp_w(ref_v, w, i >= 8);
			apb(1, 12'h000, w);
			apb(0, 12'h000, 0);
			check(rd, ref_v);
		end
		apb(0, 12'h008, 0);
		check(err, 1);
		check(rd, 0);
		$display("access test done");
		en <= 1;
		repeat (20) apb(1, 12'h000, rnd);
		@(posedge ref_clk);
		rst <= 1;
		repeat (3) @(posedge ref_clk);
		rst <= 0;
		apb(0, 12'h004, 0);
		check(rd, 0);
		repeat (10) apb(1, 12'h000, rnd);
		en <= 0;
		apb(1, 12'h004, 0);
		apb(1, 12'h000, 0);
		apb(0, 12'h000, 0);
		check(rd, 0);
		check(err, 0);
		$display("datapath test done");
		report_and_stop();
	end
endmodule // cpu_status_flag_register_test
bind cssr_top cssr_top_asserts chk (.*);
`default_nettype wire
